//--- rtl/bmb_pkg.sv
package bmb_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS    = 4;
  localparam int PROM_ACCESS_NS   = 20;
  localparam int PROM_ACC_RAW     = (PROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROM_ACC_CYC     = (PROM_ACC_RAW < 1) ? 1 : PROM_ACC_RAW;
  localparam int SAMPLE_DLY_DEF   = 16;

  // widths and counts
  localparam int KERNEL_WORDS     = 256;
  localparam int WORD_W           = 32;
  localparam int BYTE_W           = 8;
  localparam int BYTES_PER_WORD   = 4;
  localparam int KADDR_W          = 8;
  localparam int KCNT_W           = 9;
  localparam int EADDR_W          = 10;
  localparam int DLY_W            = 16;
  localparam int ACC_W            = 4;
  localparam int IDX_W            = 2;

  // derived terminal values at the width of the counters they meet
  localparam logic [ACC_W-1:0]   ACC_LAST   = ACC_W'(PROM_ACC_CYC - 1);
  localparam logic [IDX_W-1:0]   IDX_LAST   = IDX_W'(BYTES_PER_WORD - 1);
  localparam logic [KCNT_W-1:0]  KCNT_LAST  = KCNT_W'(KERNEL_WORDS - 1);
  localparam logic [KCNT_W-1:0]  KCNT_DONE  = KCNT_W'(KERNEL_WORDS);

  // reset values
  localparam logic [2:0]         SYNC_RST   = 3'h0;
  localparam logic [WORD_W-1:0]  WORD_RST   = 32'h0000_0000;
  localparam logic [EADDR_W-1:0] EADDR_RST  = 10'h000;
  localparam logic [KADDR_W-1:0] KADDR_RST  = 8'h00;
  localparam logic [KCNT_W-1:0]  KCNT_RST   = 9'h000;
  localparam logic [DLY_W-1:0]   DLY_RST    = 16'h0000;
  localparam logic [ACC_W-1:0]   ACC_RST    = 4'h0;
  localparam logic [IDX_W-1:0]   IDX_RST    = 2'h0;

  typedef enum logic [1:0] {MODE_NONE, MODE_PROM, MODE_HOST, MODE_LINK} bmb_mode_e;

  typedef enum logic [2:0] {
    ST_SAMPLE, ST_PROM_RD, ST_PROM_PUSH, ST_IDLE, ST_HOST, ST_LINK, ST_RUN
  } bmb_state_e;

endpackage

//--- rtl/bmb_word_if.sv
`timescale 1ns/1ps
interface bmb_word_if;
  import bmb_pkg::*;

  logic              valid;  // boot word offered
  logic              ready;  // dma channel takes it
  logic              last;   // the word now offered completes the kernel
  logic [WORD_W-1:0] data;   // boot word

  modport src (output valid, output data, input ready, input last);
  modport dst (input valid, input data, output ready, output last);
endinterface

//--- rtl/bmb_dma_chan.sv
`timescale 1ns/1ps
module bmb_dma_chan
  import bmb_pkg::*;
(
  input  wire logic               clk,        // system clock
  input  wire logic               rst_n,      // async reset, active low
  bmb_word_if.dst                 w,          // boot words in
  output logic                    mem_we,     // internal memory write strobe
  output logic [KADDR_W-1:0]      mem_addr,   // kernel word address
  output logic [WORD_W-1:0]       mem_wdata   // kernel word
);
  import bmb_pkg::*;

  logic [KCNT_W-1:0]  cnt_q;
  logic [KCNT_W-1:0]  cnt_d;
  logic               we_q;
  logic               we_d;
  logic [KADDR_W-1:0] addr_q;
  logic [KADDR_W-1:0] addr_d;
  logic [WORD_W-1:0]  data_q;
  logic [WORD_W-1:0]  data_d;
  logic               take;

  // channel closes itself after the kernel; later words stall at the source
  assign w.ready = (cnt_q != KCNT_DONE);
  assign w.last  = (cnt_q == KCNT_LAST);
  assign take    = w.valid && w.ready;

  // one 32-bit word per accepted transfer, addresses in arrival order
  always_comb
  begin
    cnt_d  = cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    we_d   = 1'b0;
    if (take)
    begin
      we_d   = 1'b1;
      addr_d = cnt_q[KADDR_W-1:0];
      data_d = w.data;
      cnt_d  = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= KCNT_RST;
      we_q   <= 1'b0;
      addr_q <= KADDR_RST;
      data_q <= WORD_RST;
    end
    else
    begin
      cnt_q  <= cnt_d;
      we_q   <= we_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign mem_we    = we_q;
  assign mem_addr  = addr_q;
  assign mem_wdata = data_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_dma_word_write: assert property ((w.valid && w.ready) |=> (mem_we && mem_wdata == $past(w.data)))
    else $error("accepted word not written to memory");
  a_kernel_close: assert property ((w.valid && w.ready && w.last) |=> (!w.ready ##1 !w.ready))
    else $error("channel still open after the kernel's last word");
endmodule

//--- rtl/bmb_boot_loader.sv
`timescale 1ns/1ps
module bmb_boot_loader
  import bmb_pkg::*;
#(
  parameter int SAMPLE_DLY = SAMPLE_DLY_DEF  // cycles after release before mode is taken
)
(
  input  wire logic                     SYS_CLK,      // 250 MHz system clock
  input  wire logic                     RSTN,         // async reset, active low
  input  wire logic                     BOOT_SEL_PIN, // boot select pin level
  output logic                          BOOT_SEL_CS_N, // chip select drive, active low
  output logic                          BOOT_SEL_OE,  // high while pin is driven
  output logic [EADDR_W-1:0]            EMEM_ADDR,    // byte address to boot memory
  input  wire logic [BYTE_W-1:0]        EMEM_DATA,    // byte from boot memory
  input  wire logic                     HOST_WR,      // host write to boot dma port
  input  wire logic [WORD_W-1:0]        HOST_WDATA,   // host boot word
  output logic                          HOST_ACK,     // host write taken
  input  wire logic                     LINK_VALID,   // link word offered
  input  wire logic [WORD_W-1:0]        LINK_DATA,    // link boot word
  output logic                          LINK_READY,   // link word taken
  output logic                          MEM_WE,       // kernel memory write
  output logic [KADDR_W-1:0]            MEM_ADDR,     // kernel word address
  output logic [WORD_W-1:0]             MEM_WDATA,    // kernel word
  output bmb_pkg::bmb_mode_e            BOOT_MODE,    // selected boot mode
  output logic                          EXEC_START,   // one-cycle start of kernel
  output logic                          EXEC_RUN      // kernel running
);
  import bmb_pkg::*;

  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(SAMPLE_DLY - 1);

  bmb_word_if w_if ();

  bmb_state_e          state_q;
  bmb_state_e          state_d;
  bmb_mode_e           mode_q;
  bmb_mode_e           mode_d;
  logic [2:0]          sync_q;
  logic [2:0]          sync_d;
  logic [DLY_W-1:0]    dly_q;
  logic [DLY_W-1:0]    dly_d;
  logic [ACC_W-1:0]    acc_q;
  logic [ACC_W-1:0]    acc_d;
  logic [IDX_W-1:0]    idx_q;
  logic [IDX_W-1:0]    idx_d;
  logic [EADDR_W-1:0]  eaddr_q;
  logic [EADDR_W-1:0]  eaddr_d;
  logic [WORD_W-1:0]   word_q;
  logic [WORD_W-1:0]   word_d;
  logic                cs_n_q;
  logic                cs_n_d;
  logic                oe_q;
  logic                oe_d;
  logic                start_q;
  logic                start_d;
  logic                run_q;
  logic                run_d;
  logic                sel_agree;
  logic                take;

  // three-stage pin synchroniser; first stage feeds only the second
  assign sync_d    = {sync_q[1:0], BOOT_SEL_PIN};
  assign sel_agree = (sync_q[1] == sync_q[2]);

  // source mux: prom packer, or first of host/link, then locked
  always_comb
  begin
    w_if.valid = 1'b0;
    w_if.data  = word_q;
    HOST_ACK   = 1'b0;
    LINK_READY = 1'b0;
    case (state_q)
      ST_PROM_PUSH:
      begin
        w_if.valid = 1'b1;
      end
      ST_IDLE:
      begin
        // host wins a tie, link is then locked out for the rest of the boot
        w_if.valid = HOST_WR || LINK_VALID;
        w_if.data  = HOST_WR ? HOST_WDATA : LINK_DATA;
        HOST_ACK   = HOST_WR && w_if.ready;
        LINK_READY = !HOST_WR && w_if.ready;
      end
      ST_HOST:
      begin
        w_if.valid = HOST_WR;
        w_if.data  = HOST_WDATA;
        HOST_ACK   = w_if.ready;
      end
      ST_LINK:
      begin
        w_if.valid = LINK_VALID;
        w_if.data  = LINK_DATA;
        LINK_READY = w_if.ready;
      end
      default:
      begin
        w_if.valid = 1'b0;
      end
    endcase
  end

  assign take = w_if.valid && w_if.ready;

  // boot sequencer next state
  always_comb
  begin
    state_d = state_q;
    mode_d  = mode_q;
    dly_d   = dly_q;
    acc_d   = acc_q;
    idx_d   = idx_q;
    eaddr_d = eaddr_q;
    word_d  = word_q;
    case (state_q)
      ST_SAMPLE:
      begin
        // pin stays an input; a level is taken only when stages agree
        if (dly_q != DLY_LAST)
          dly_d = dly_q + 1'b1;
        else if (sel_agree)
        begin
          if (!sync_q[2])
          begin
            state_d = ST_PROM_RD;
            mode_d  = MODE_PROM;
          end
          else
            state_d = ST_IDLE;
        end
      end
      ST_PROM_RD:
      begin
        // fixed access time per byte, little-endian packing
        if (acc_q != ACC_LAST)
          acc_d = acc_q + 1'b1;
        else
        begin
          acc_d                       = ACC_RST;
          word_d[idx_q*BYTE_W +: BYTE_W] = EMEM_DATA;
          eaddr_d                     = eaddr_q + 1'b1;
          idx_d                       = idx_q + 1'b1;
          if (idx_q == IDX_LAST)
            state_d = ST_PROM_PUSH;
        end
      end
      ST_PROM_PUSH:
      begin
        if (take)
          state_d = w_if.last ? ST_RUN : ST_PROM_RD;
      end
      ST_IDLE:
      begin
        if (take)
        begin
          mode_d = HOST_WR ? MODE_HOST : MODE_LINK;
          if (w_if.last)
            state_d = ST_RUN;
          else
            state_d = HOST_WR ? ST_HOST : ST_LINK;
        end
      end
      ST_HOST, ST_LINK:
      begin
        if (take && w_if.last)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_SAMPLE;
      end
    endcase
  end

  // chip select and execution flags follow the next state, pin enable follows the next mode
  always_comb
  begin
    cs_n_d  = (state_d != ST_PROM_RD);
    oe_d    = (mode_d == MODE_PROM);
    run_d   = (state_d == ST_RUN);
    start_d = (state_d == ST_RUN) && (state_q != ST_RUN);
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= ST_SAMPLE;
      mode_q  <= MODE_NONE;
      sync_q  <= SYNC_RST;
      dly_q   <= DLY_RST;
      acc_q   <= ACC_RST;
      idx_q   <= IDX_RST;
      eaddr_q <= EADDR_RST;
      word_q  <= WORD_RST;
      cs_n_q  <= 1'b1;
      oe_q    <= 1'b0;
      start_q <= 1'b0;
      run_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mode_q  <= mode_d;
      sync_q  <= sync_d;
      dly_q   <= dly_d;
      acc_q   <= acc_d;
      idx_q   <= idx_d;
      eaddr_q <= eaddr_d;
      word_q  <= word_d;
      cs_n_q  <= cs_n_d;
      oe_q    <= oe_d;
      start_q <= start_d;
      run_q   <= run_d;
    end
  end

  bmb_dma_chan u_dma (
    .clk       (SYS_CLK),
    .rst_n     (RSTN),
    .w         (w_if),
    .mem_we    (MEM_WE),
    .mem_addr  (MEM_ADDR),
    .mem_wdata (MEM_WDATA)
  );

  assign BOOT_SEL_CS_N = cs_n_q;
  assign BOOT_SEL_OE = oe_q;
  assign EMEM_ADDR   = eaddr_q;
  assign BOOT_MODE   = mode_q;
  assign EXEC_START  = start_q;
  assign EXEC_RUN    = run_q;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_pin_input_sample: assert property ((state_q == ST_SAMPLE) |-> !BOOT_SEL_OE)
    else $error("boot select pin driven before mode is taken");
  a_prom_cs_drive: assert property ((state_q == ST_SAMPLE && state_d == ST_PROM_RD)
    |=> (BOOT_SEL_OE && !BOOT_SEL_CS_N && BOOT_MODE == MODE_PROM))
    else $error("prom boot did not turn pin into chip select");
  a_idle_no_drive: assert property ((state_q == ST_IDLE) |-> (!BOOT_SEL_OE && !MEM_WE))
    else $error("pin driven or memory written while idle");
  a_prom_byte_time: assert property ($fell(BOOT_SEL_CS_N) |-> !BOOT_SEL_CS_N [*5])
    else $error("chip select shorter than one byte access");
  a_host_final_run: assert property ((state_q == ST_HOST && take && w_if.last)
    |=> (EXEC_START && EXEC_RUN))
    else $error("no start after final host word");
  a_link_locked: assert property ((state_q == ST_LINK) |-> (!HOST_ACK && BOOT_MODE == MODE_LINK))
    else $error("host accepted during link boot");
  a_start_single: assert property (EXEC_START |=> (EXEC_RUN && !EXEC_START) ##1 EXEC_RUN)
    else $error("start not a single pulse into run");
  a_sample_delay: assert property ((state_q == ST_SAMPLE && state_d != ST_SAMPLE)
    |-> (dly_q == DLY_LAST && $stable(state_q)))
    else $error("mode taken before the sample delay elapsed");
endmodule

//--- tb/bmb_prom_model.sv
`timescale 1ns/1ps
module bmb_prom_model
  import bmb_pkg::*;
(
  input  wire logic               clk,   // system clock
  input  wire logic               cs_n,  // chip select level, active low
  input  wire logic [EADDR_W-1:0] addr,  // byte address
  output logic      [BYTE_W-1:0]  data   // byte to the device
);
  logic [BYTE_W-1:0]  last_q = 8'h00;
  logic [EADDR_W-1:0] addr_q = 10'h000;
  logic               cs_n_q = 1'b1;
  int                 age_q  = 0;
  logic               fresh;
  logic               valid;

  // a new address or a new select restarts the access time
  assign fresh = (addr != addr_q) || (cs_n != cs_n_q);
  assign valid = !cs_n && !fresh && (age_q >= PROM_ACC_CYC - 1);

  // byte only after the access time; else inverse of last, so early sampling fails
  always_comb
  begin
    if (valid)
      data = addr[7:0] ^ {6'h00, addr[9:8]} ^ 8'h5a;
    else
      data = ~last_q;
  end

  // remember bus, address and select of the last cycle, count access age
  always @(posedge clk)
  begin
    last_q <= data;
    addr_q <= addr;
    cs_n_q <= cs_n;
    if (fresh)
      age_q <= 1;
    else if (age_q < PROM_ACC_CYC)
      age_q <= age_q + 1;
  end
endmodule

//--- tb/test_boot_mode_select_bootstrap.sv
`timescale 1ns/1ps
module test_boot_mode_select_bootstrap;
  import bmb_pkg::*;
  localparam int SDLY = 4;

  logic               sys_clk    = 1'b0;
  logic               rstn       = 1'b0;
  logic               sel_lvl    = 1'b0;
  logic               host_wr    = 1'b0;
  logic [WORD_W-1:0]  host_wdata = 32'h0000_0000;
  logic               link_valid = 1'b0;
  logic [WORD_W-1:0]  link_data  = 32'h0000_0000;
  logic               boot_cs_n;
  logic               boot_sel_oe;
  logic [EADDR_W-1:0] emem_addr;
  logic [BYTE_W-1:0]  emem_data;
  logic               host_ack;
  logic               link_ready;
  logic               mem_we;
  logic [KADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0]  mem_wdata;
  bmb_mode_e          boot_mode;
  logic               exec_start;
  logic               exec_run;
  wire                boot_sel_pin;
  int                 fails = 0;
  int                 check_count = 0;

  always #2 sys_clk = ~sys_clk;
  // strap level shows only while the device leaves the pin undriven
  assign boot_sel_pin = boot_sel_oe ? boot_cs_n : sel_lvl;

  bmb_boot_loader #(.SAMPLE_DLY(SDLY)) bmb_boot_loader_i (
    .SYS_CLK(sys_clk), .RSTN(rstn), .BOOT_SEL_PIN(boot_sel_pin), .BOOT_SEL_CS_N(boot_cs_n),
    .BOOT_SEL_OE(boot_sel_oe), .EMEM_ADDR(emem_addr), .EMEM_DATA(emem_data),
    .HOST_WR(host_wr), .HOST_WDATA(host_wdata), .HOST_ACK(host_ack),
    .LINK_VALID(link_valid), .LINK_DATA(link_data), .LINK_READY(link_ready),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .BOOT_MODE(boot_mode), .EXEC_START(exec_start), .EXEC_RUN(exec_run));

  bmb_prom_model bmb_prom_model_i (
    .clk(sys_clk), .cs_n(boot_sel_pin), .addr(emem_addr), .data(emem_data));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [7:0] pbyte(input int a);
    logic [9:0] x;
    x = 10'(a);
    return x[7:0] ^ {6'h00, x[9:8]} ^ 8'h5a;
  endfunction

  function automatic logic [31:0] wpat(input int k, input logic lnk);
    logic [7:0] b;
    b = 8'(k);
    return {~b, {7'h00, lnk}, b, b ^ 8'h3c};
  endfunction

  task automatic do_reset(input logic lvl);
    @(negedge sys_clk);
    rstn = 1'b0;
    sel_lvl = lvl;
    host_wr = 1'b0;
    link_valid = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("pin enable in reset", 0, boot_sel_oe);
    chk("mode in reset", MODE_NONE, boot_mode);
    chk("run in reset", 0, exec_run);
    rstn = 1'b1;
  endtask

  // start pulse within a few cycles of the last word, then running for good
  task automatic chk_start();
    int i;
    for (i = 0; i < 8 && exec_start !== 1'b1; i++) @(negedge sys_clk);
    chk("start pulse", 1, exec_start);
    chk("run level", 1, exec_run);
    @(negedge sys_clk);
    chk("start ends", 0, exec_start);
    chk("run holds", 1, exec_run);
  endtask

  task automatic test_prom();
    int n;
    int i;
    logic [31:0] w;
    do_reset(1'b0);
    repeat (SDLY + 6) @(negedge sys_clk);
    chk("prom mode", MODE_PROM, boot_mode);
    chk("pin driven", 1, boot_sel_oe);
    chk("chip select low", 0, boot_cs_n);
    for (n = 0; n < KERNEL_WORDS; n++)
    begin
      for (i = 0; i < 4; i++) w[8*i +: 8] = pbyte(4 * n + i);
      for (i = 0; i < 60 && mem_we !== 1'b1; i++) @(negedge sys_clk);
      chk("prom write", 1, mem_we);
      chk("prom address", n, mem_addr);
      chk("prom word", w, mem_wdata);
      chk("prom byte address", (4 * n + 4) % (1 << EADDR_W), emem_addr);
      chk("chip select", n == KERNEL_WORDS - 1, boot_cs_n);
      if (n < KERNEL_WORDS - 1)
        @(negedge sys_clk);
    end
    chk_start();
    $display("prom boot test done");
  endtask

  task automatic test_stream(input logic lnk);
    int k;
    int i;
    do_reset(1'b1);
    for (k = 0; k < KERNEL_WORDS; k++)
    begin
      // one 32-bit word per write, offered back to back
      if (lnk)
      begin
        link_valid = 1'b1;
        link_data = wpat(k, lnk);
      end
      else
      begin
        host_wr = 1'b1;
        host_wdata = wpat(k, lnk);
      end
      if (k == 0)
      begin
        @(negedge sys_clk);
        chk("no take while sampling", 0, lnk ? link_ready : host_ack);
      end
      for (i = 0; i < SDLY + 40 && (lnk ? link_ready : host_ack) !== 1'b1; i++)
        @(negedge sys_clk);
      chk("word taken", 1, lnk ? link_ready : host_ack);
      if (k == 0)
        chk("sample delay", SDLY - 1, i);
      @(negedge sys_clk);
      chk("stream write", 1, mem_we);
      chk("stream address", k, mem_addr);
      chk("stream word", wpat(k, lnk), mem_wdata);
    end
    host_wr = 1'b0;
    link_valid = 1'b0;
    chk("stream mode", lnk ? MODE_LINK : MODE_HOST, boot_mode);
    chk("pin undriven", 0, boot_sel_oe);
    chk_start();
    // a word past the kernel is refused on both paths
    host_wr = 1'b1;
    link_valid = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("host after kernel", 0, host_ack);
    chk("link after kernel", 0, link_ready);
    host_wr = 1'b0;
    link_valid = 1'b0;
    $display("stream boot test done, link %0d", lnk);
  endtask

  // both sources offer in idle: host takes the word, link stays locked out
  task automatic test_tie();
    int i;
    do_reset(1'b1);
    host_wr = 1'b1;
    link_valid = 1'b1;
    host_wdata = wpat(0, 1'b0);
    link_data = wpat(0, 1'b1);
    for (i = 0; i < SDLY + 40 && host_ack !== 1'b1; i++) @(negedge sys_clk);
    chk("tie host ack", 1, host_ack);
    chk("tie link held", 0, link_ready);
    @(negedge sys_clk);
    chk("tie word", wpat(0, 1'b0), mem_wdata);
    chk("tie mode", MODE_HOST, boot_mode);
    chk("tie link locked", 0, link_ready);
    host_wr = 1'b0;
    link_valid = 1'b0;
    $display("tie test done");
  endtask

  // whole run is near 6000 cycles; allow far more before calling it hung
  initial
  begin
    #200000;
    fails++;
    $display("unexpected watchdog: expected end of tests, seen timeout");
    close_out();
  end

  initial
  begin
    test_prom();
    test_tie();
    test_stream(1'b0);
    test_stream(1'b1);
    close_out();
  end
endmodule
